// ---- bench/fast_pulse_counters_tb.sv ----
/*
  Self-checking bench of the fast pulse counters: APB master, pulse source
  model and a reference model of counts and switching outputs.
  Assumes fpc_cfg.svh, fpc_pkg and a 100 MHz clock.
*/
`timescale 1ns/10ps
`include "fpc_cfg.svh"
`define CHECK(nm, e, g) \
  begin \
    n_compared++; \
    if ((e) !== (g)) begin \
      errors++; \
      $display("mismatch %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module fast_pulse_counters_tb
  import fpc_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic        rate_en_in = 1'b0;
  logic        rate_rst_in = 1'b0;
  logic        ud_rst_in = 1'b0;
  logic        qd_rst_in = 1'b0;
  wire         pulse_in, up_pulse_in, down_pulse_in, phase_a_in, phase_b_in;
  wire         pready_out, pslverr_out, rate_q_out, ud_q_out, qd_q_out;
  wire  [31:0] prdata_out, rate_value_out, ud_value_out, qd_value_out;
  logic [31:0] rdata, seed = 32'h6911;
  logic        err;
  int          errors = 0, n_compared = 0, ud_cnt, qd_cnt, ud_pre, qd_pre;
  int          ex, nu, nd, nf, nb, d;
  bit          q, fwd, atog, qa = 1'b0, qb = 1'b0;
  int          c_fall[4] = '{0, 1, 0, 1};
  int          c_on[4] = '{10, 10, 5, 5};
  int          c_off[4] = '{5, 5, 10, 10};
  int          c_n[4] = '{24, 15, 14, 23};
  localparam logic [31:0] UD = (32'h1 << `CTL_UHS) | (32'h1 << `CTL_URUN);
  localparam logic [31:0] UDOFF = 32'h1 << `CTL_UHS;
  // Clock, 10 ns period
  always #5 clk_in = ~clk_in;
  fast_pulse_counters #(
    .FILTER_CYCLES (4),
    .TICK_CYCLES   (5)
  ) u_dut (
    .clk_in         (clk_in),
    .resetn_in      (resetn_in),
    .psel_in        (psel_in),
    .penable_in     (penable_in),
    .pwrite_in      (pwrite_in),
    .paddr_in       (paddr_in),
    .pwdata_in      (pwdata_in),
    .pready_out     (pready_out),
    .pslverr_out    (pslverr_out),
    .prdata_out     (prdata_out),
    .rate_en_in     (rate_en_in),
    .pulse_in       (pulse_in),
    .rate_rst_in    (rate_rst_in),
    .up_pulse_in    (up_pulse_in),
    .down_pulse_in  (down_pulse_in),
    .ud_rst_in      (ud_rst_in),
    .phase_a_in     (phase_a_in),
    .phase_b_in     (phase_b_in),
    .qd_rst_in      (qd_rst_in),
    .rate_q_out     (rate_q_out),
    .ud_q_out       (ud_q_out),
    .qd_q_out       (qd_q_out),
    .rate_value_out (rate_value_out),
    .ud_value_out   (ud_value_out),
    .qd_value_out   (qd_value_out)
  );
  pulse_source u_src (
    .clk_in    (clk_in),
    .pulse_out (pulse_in),
    .up_out    (up_pulse_in),
    .down_out  (down_pulse_in),
    .pha_out   (phase_a_in),
    .phb_out   (phase_b_in)
  );
  // Xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Reference of the rate switch output; hold only in hysteresis mode
  function automatic bit rate_q(int r, int on, int off, bit prev);
    if (on >= off) begin
      return (r >= on) ? 1'b1 : ((r < off) ? 1'b0 : prev);
    end
    return (r >= on) && (r < off);
  endfunction
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic test_done();
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] dat);
    int k;
    @(posedge clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= dat;
    @(posedge clk_in);
    penable_in <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready_out !== 1'b1 && k < 16);
    if (pready_out !== 1'b1) begin
      errors++;
      test_done();
    end
    rdata = prdata_out;
    err   = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // Per-function reset pin pulse, long enough to pass the synchroniser
  task automatic fn_reset(input int f);
    case (f)
      0: rate_rst_in <= 1'b1;
      1: ud_rst_in <= 1'b1;
      default: qd_rst_in <= 1'b1;
    endcase
    wait_cyc(8);
    case (f)
      0: rate_rst_in <= 1'b0;
      1: ud_rst_in <= 1'b0;
      default: qd_rst_in <= 1'b0;
    endcase
  endtask
  // Main sequence
  initial begin
    wait_cyc(8);
    resetn_in <= 1'b1;
    apb(0, `OFS_CTRL, 0);
    `CHECK("ctrl", `CTRL_RST, rdata)
    apb(0, `OFS_GATE, 0);
    `CHECK("gate", `GATE_RST, rdata)
    apb(0, `OFS_UDPRE, 0);
    `CHECK("ud preset", `PRE_RST, rdata)
    apb(0, 8'h28, 0);
    `CHECK("unmapped err", 1'b1, err)
    apb(1, `OFS_RATE, 32'h5);
    `CHECK("read-only err", 1'b1, err)
    apb(1, `OFS_ON, 32'hffff_ffff);
    apb(0, `OFS_ON, 0);
    `CHECK("on clamp", `ON_MAX, rdata)
    apb(1, `OFS_OFF, 32'hffff_ffff);
    apb(0, `OFS_OFF, 0);
    `CHECK("off clamp", `OFF_MAX, rdata)
    apb(1, `OFS_GATE, 32'h0);
    apb(0, `OFS_GATE, 0);
    `CHECK("gate clamp", `GATE_MIN, rdata)
    // Rate switch: edge modes, hysteresis and window thresholds
    for (int i = 0; i < 4; i++) begin
      apb(1, `OFS_CTRL, (32'h1 << `CTL_RHS) | c_fall[i]);
      apb(1, `OFS_ON, c_on[i]);
      apb(1, `OFS_OFF, c_off[i]);
      apb(1, `OFS_GATE, 40);
      @(posedge clk_in);
      rate_en_in <= 1'b1;
      wait_cyc(10);
      u_src.toggle(0, c_n[i], 4);
      wait_cyc(290 - 4 * c_n[i]);
      ex = c_fall[i] ? c_n[i] / 2 : (c_n[i] + 1) / 2;
      q = rate_q(ex, c_on[i], c_off[i], 1'b0);
      `CHECK("rate", ex, rate_value_out)
      `CHECK("rate_q", q, rate_q_out)
      apb(0, `OFS_RATE, 0);
      `CHECK("rate reg", ex, rdata)
      if (i % 2) begin
        // Pulses during reset must not be counted
        fork
          fn_reset(0);
          u_src.toggle(0, 2, 3);
        join
        wait_cyc(2);
        `CHECK("rate rst", 0, rate_value_out)
        `CHECK("rate_q rst", 1'b0, rate_q_out)
      end else begin
        wait_cyc(200);
        `CHECK("rate idle", 0, rate_value_out)
        `CHECK("rate_q idle", rate_q(0, c_on[i], c_off[i], q),
               rate_q_out)
      end
      rate_en_in <= 1'b0;
      if (c_n[i] % 2) u_src.toggle(0, 1, 3);
      fn_reset(0);
    end
    // Up/down counter with random bursts, overlapping up and down
    apb(1, `OFS_CTRL, UD);
    ud_pre = 1 + rnd() % 10;
    apb(1, `OFS_UDPRE, ud_pre);
    ud_cnt = 0;
    for (int i = 0; i < 3; i++) begin
      nu = rnd() % 12;
      nd = rnd() % 12;
      fork
        u_src.toggle(1, 2 * nu, 3);
        u_src.toggle(2, 2 * nd, 4);
      join
      ud_cnt += nu - nd;
      wait_cyc(6);
      `CHECK("ud", 32'(ud_cnt), ud_value_out)
      `CHECK("ud_q", ud_cnt >= ud_pre, ud_q_out)
      apb(0, `OFS_UDVAL, 0);
      `CHECK("ud reg", 32'(ud_cnt), rdata)
    end
    apb(1, `OFS_CTRL, UDOFF);
    apb(1, `OFS_CTRL, UD | (32'h1 << `CTL_URET));
    wait_cyc(2);
    `CHECK("ud kept", 32'(ud_cnt), ud_value_out)
    apb(1, `OFS_CTRL, UDOFF);
    apb(1, `OFS_CTRL, UD);
    wait_cyc(2);
    `CHECK("ud cleared", 0, ud_value_out)
    u_src.toggle(1, 6, 3);
    fork
      fn_reset(1);
      u_src.toggle(1, 2, 3);
    join
    wait_cyc(2);
    `CHECK("ud rst", 0, ud_value_out)
    `CHECK("ud_q rst", 1'b0, ud_q_out)
    // Quadrature counter in every decoding mode, forward then back
    for (int m = 0; m < 4; m++) begin
      apb(1, `OFS_CTRL, 32'h0);
      apb(1, `OFS_CTRL, (32'h1 << `CTL_QRUN) | (32'(m) << `CTL_QM_LO));
      qd_pre = 1 + rnd() % 8;
      apb(1, `OFS_QDPRE, qd_pre);
      qd_cnt = 0;
      nf = 6 + rnd() % 8;
      nb = rnd() % 6;
      for (int s = 0; s < nf + nb; s++) begin
        fwd = s < nf;
        atog = ((qa == qb) == fwd);
        d = fwd ? 1 : -1;
        if (atog) begin
          qd_cnt += (m == QD_X1 && qa) ? 0 : d;
          qa = ~qa;
        end else begin
          qd_cnt += (m >= QD_X4) ? d : 0;
          qb = ~qb;
        end
        u_src.step(fwd);
      end
      wait_cyc(6);
      `CHECK("qd", 32'(qd_cnt), qd_value_out)
      `CHECK("qd_q", qd_cnt >= qd_pre, qd_q_out)
      apb(0, `OFS_QDVAL, 0);
      `CHECK("qd reg", 32'(qd_cnt), rdata)
      if (qa == qb) qa = ~qa;
      else qb = ~qb;
      fork
        fn_reset(2);
        u_src.step(1'b1);
      join
      wait_cyc(2);
      `CHECK("qd rst", 0, qd_value_out)
      `CHECK("qd_q rst", 1'b0, qd_q_out)
    end
    test_done();
  end
endmodule

// ---- bench/pulse_source.sv ----
/*
  Pulse source model for the fast inputs: rate pulse, up, down and the
  two quadrature phases. Assumes the bench clock; every level changes just
  after a rising edge and is held for at least three cycles.
*/
`timescale 1ns/10ps
module pulse_source (
  // Clock
  input  wire logic clk_in,
  // Fast input lines, each feeding exactly one function
  output logic      pulse_out,
  output logic      up_out,
  output logic      down_out,
  output logic      pha_out,
  output logic      phb_out
);
  // Lines idle low so the first edge of a burst is a rise
  initial begin
    pulse_out = 1'b0;
    up_out    = 1'b0;
    down_out  = 1'b0;
    pha_out   = 1'b0;
    phb_out   = 1'b0;
  end
  // Toggle one line n times; short holds need the high-speed path
  task automatic toggle(input int line, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      repeat (hold) @(posedge clk_in);
      case (line)
        0: pulse_out <= ~pulse_out;
        1: up_out <= ~up_out;
        default: down_out <= ~down_out;
      endcase
    end
  endtask
  // One Gray step on the phase pair; forward lets A lead
  task automatic step(input bit fwd);
    repeat (4) @(posedge clk_in);
    if ((pha_out == phb_out) == fwd) begin
      pha_out <= ~pha_out;
    end else begin
      phb_out <= ~phb_out;
    end
  endtask
endmodule

// ---- rtl/fast_pulse_counters.sv ----
/*
  Fast pulse counters: a rate threshold switch, an up/down counter and a
  quadrature counter behind an APB slave. Assumes asynchronous pins on the
  pulse, enable and per-function reset inputs, and one 100 MHz clock.
*/
// Design decisions made here: the register offsets and the APB register port.
// How it works
// - Rate switch starts measuring on enable rise, stops on enable fall.
// - Rising-edge mode counts only low-to-high pulse transitions.
// - Falling-edge mode counts only high-to-low pulse transitions.
// - Rate switch reset clears count and output, beating any pulse.
// - On threshold up to 99999999, off up to 999999999.
// - Gate time from 10 ms to 999:59:59.990.
// - On >= off: set at rate >= on, clear below off, else hold.
// - On < off: output high only for on <= rate < off.
// - Up/down counter counts rising edges: up input +1, down -1.
// - Up/down reset clears count and output over both inputs.
// - Up/down preset 0 to 99999999; output set when reached.
// - Up/down retention and high-speed path chosen by configuration.
// - Quadrature counter decodes two phases at x1, x2 or x4.
// - Quadrature reset clears count and output over both phases.
// - Quadrature output set when count reaches preset.
// - Quadrature retention chosen by configuration.
// - Both counters publish their count into a wide value register.
// - Rate switch publishes its measured rate into a value register.
// - Value taps carry each running value out for display.
`timescale 1ns/10ps
`include "fpc_cfg.svh"
module fast_pulse_counters
  import fpc_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = `FILT_CYC,
  parameter int unsigned TICK_CYCLES   = `TICK_CYC
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [31:0]      prdata_out,
  // Pulse pins
  input  wire logic        rate_en_in,
  input  wire logic        pulse_in,
  input  wire logic        rate_rst_in,
  input  wire logic        up_pulse_in,
  input  wire logic        down_pulse_in,
  input  wire logic        ud_rst_in,
  input  wire logic        phase_a_in,
  input  wire logic        phase_b_in,
  input  wire logic        qd_rst_in,
  // Switching outputs and value taps
  output logic             rate_q_out,
  output logic             ud_q_out,
  output logic             qd_q_out,
  output logic [31:0]      rate_value_out,
  output logic [31:0]      ud_value_out,
  output logic [31:0]      qd_value_out
);

  // Edge finder shared by the rate and up/down counting paths
  function automatic logic rose(input logic cur, input logic prv);
    rose = cur & ~prv;
  endfunction

  // Clamp a written value into its legal range
  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction

  // Two-stage synchronisers; stage one feeds stage two only
  logic [8:0] sync1_reg;
  logic [8:0] sync2_reg;
  wire  [8:0] pin_vec = {qd_rst_in, phase_b_in, phase_a_in, ud_rst_in,
                         down_pulse_in, up_pulse_in, rate_rst_in, pulse_in,
                         rate_en_in};
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_reg <= 9'h000;
      sync2_reg <= 9'h000;
    end else begin
      sync1_reg <= pin_vec;
      sync2_reg <= sync1_reg;
    end
  end
  wire rate_en  = sync2_reg[0];
  wire rate_rst = sync2_reg[2];
  wire ud_rst   = sync2_reg[5];
  wire qd_rst   = sync2_reg[8];

  // Control and parameter registers
  logic [8:0]  ctrl_reg;
  logic [31:0] on_reg;
  logic [31:0] off_reg;
  logic [31:0] gate_reg;
  logic [31:0] udpre_reg;
  logic [31:0] qdpre_reg;
  wire         ud_hs  = ctrl_reg[`CTL_UHS];
  wire         rate_hs = ctrl_reg[`CTL_RHS];
  wire         ud_run = ctrl_reg[`CTL_URUN];
  wire         qd_run = ctrl_reg[`CTL_QRUN];
  wire qd_mode_type qd_mode = qd_mode_type'(ctrl_reg[`CTL_QM_HI:`CTL_QM_LO]);

  // Input filter for the non-quadrature pulses; high-speed bypasses it.
  // Phases never pass the filter, since quadrature always runs fast.
  wire  [2:0] filt_src = {sync2_reg[4], sync2_reg[3], sync2_reg[1]};
  wire  [2:0] hs_sel   = {ud_hs, ud_hs, rate_hs};
  wire  [2:0] filt_lvl;
  logic [4:0] lvl;
  logic [4:0] prev_reg;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_filt
      logic [22:0] fcnt_reg;
      logic        stable_reg;
      // Each lane owns its level flop, so no flop has two writers
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          fcnt_reg   <= 23'h000000;
          stable_reg <= 1'b0;
        end else if (filt_src[gi] == stable_reg) begin
          fcnt_reg <= 23'h000000;
        end else if (fcnt_reg == 23'(FILTER_CYCLES - 1)) begin
          fcnt_reg   <= 23'h000000;
          stable_reg <= filt_src[gi];
        end else begin
          fcnt_reg <= fcnt_reg + 23'h000001;
        end
      end
      assign filt_lvl[gi] = stable_reg;
      assign lvl[gi] = hs_sel[gi] ? filt_src[gi] : filt_lvl[gi];
    end
  endgenerate
  assign lvl[4:3] = {sync2_reg[7], sync2_reg[6]};

  // Previous sampled levels for edge detection
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) prev_reg <= 5'h00;
    else            prev_reg <= lvl;
  end

  // Rate switch: state and edge selection
  rate_state_type state_reg;
  rate_state_type state_next;
  logic           en_prev_reg;
  wire en_rise = rate_en & ~en_prev_reg;
  wire en_fall = ~rate_en & en_prev_reg;
  wire pulse_edge = ctrl_reg[`CTL_FALL] ?
                    rose(prev_reg[0], lvl[0]) :
                    rose(lvl[0], prev_reg[0]);
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      RATE_IDLE: if (en_rise) state_next = RATE_MEAS;
      RATE_MEAS: if (en_fall) state_next = RATE_IDLE;
    endcase
  end

  // Rate switch: gate timing in 10 ms ticks
  logic [19:0] tick_reg;
  logic [31:0] gcnt_reg;
  logic [31:0] edge_reg;
  logic [31:0] rate_reg;
  logic        rate_q_reg;
  wire measuring = (state_reg == RATE_MEAS);
  wire start     = (state_reg == RATE_IDLE) & en_rise;
  wire tick_last = (tick_reg == 20'(TICK_CYCLES - 1));
  wire gate_last = (gcnt_reg + 32'h1 >= gate_reg);
  wire gate_end  = measuring & ~en_fall & tick_last & gate_last;
  wire [31:0] rate_new = edge_reg + {31'h0, pulse_edge};
  // Hysteresis when on >= off, window otherwise
  wire q_eval = (on_reg >= off_reg) ?
                ((rate_new >= on_reg) ? 1'b1 :
                 ((rate_new < off_reg) ? 1'b0 : rate_q_reg)) :
                ((rate_new >= on_reg) && (rate_new < off_reg));

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg   <= RATE_IDLE;
      en_prev_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      en_prev_reg <= rate_en;
    end
  end

  // Reset pin wins over any pulse in the same cycle
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tick_reg   <= 20'h00000;
      gcnt_reg   <= 32'h0;
      edge_reg   <= 32'h0;
      rate_reg   <= 32'h0;
      rate_q_reg <= 1'b0;
    end else if (rate_rst || start) begin
      tick_reg <= 20'h00000;
      gcnt_reg <= 32'h0;
      edge_reg <= 32'h0;
      if (rate_rst) begin
        rate_reg   <= 32'h0;
        rate_q_reg <= 1'b0;
      end
    end else if (measuring && !en_fall) begin
      tick_reg <= tick_last ? 20'h00000 : tick_reg + 20'h00001;
      if (tick_last) gcnt_reg <= gate_last ? 32'h0 : gcnt_reg + 32'h1;
      edge_reg <= gate_end ? 32'h0 : rate_new;
      if (gate_end) begin
        rate_reg   <= rate_new;
        rate_q_reg <= q_eval;
      end
    end
  end

  // Up/down counter; simultaneous up and down cancel out
  logic        ud_run_prev_reg;
  logic [31:0] ud_cnt_reg;
  logic        ud_q_reg;
  wire ud_inc = ud_run & rose(lvl[1], prev_reg[1]);
  wire ud_dec = ud_run & rose(lvl[2], prev_reg[2]);
  // Retention keeps the count over a restart of counting
  wire ud_clr = ud_rst |
                (ud_run & ~ud_run_prev_reg & ~ctrl_reg[`CTL_URET]);
  wire [31:0] ud_cnt_next =
    ud_clr            ? 32'h0 :
    (ud_inc & ~ud_dec) ? ud_cnt_reg + 32'h1 :
    (ud_dec & ~ud_inc) ? ud_cnt_reg - 32'h1 : ud_cnt_reg;

  // Quadrature decoding
  wire a  = lvl[3];
  wire b  = lvl[4];
  wire ea = a ^ prev_reg[3];
  wire eb = b ^ prev_reg[4];
  logic qd_valid;
  logic qd_up;
  always_comb begin
    unique case (qd_mode)
      QD_X1: begin
        qd_valid = ea & a & ~eb;
        qd_up    = ~b;
      end
      QD_X2: begin
        qd_valid = ea & ~eb;
        qd_up    = a ^ b;
      end
      default: begin
        qd_valid = ea ^ eb;
        qd_up    = ea ? (a ^ b) : ~(a ^ b);
      end
    endcase
  end
  logic        qd_run_prev_reg;
  logic [31:0] qd_cnt_reg;
  logic        qd_q_reg;
  wire qd_clr = qd_rst |
                (qd_run & ~qd_run_prev_reg & ~ctrl_reg[`CTL_QRET]);
  wire [31:0] qd_cnt_next =
    qd_clr                ? 32'h0 :
    !(qd_run && qd_valid) ? qd_cnt_reg :
    qd_up                 ? qd_cnt_reg + 32'h1 :
                            qd_cnt_reg - 32'h1;

  // Counter registers; outputs compare the signed count with the preset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ud_run_prev_reg <= 1'b0;
      qd_run_prev_reg <= 1'b0;
      ud_cnt_reg      <= 32'h0;
      qd_cnt_reg      <= 32'h0;
      ud_q_reg        <= 1'b0;
      qd_q_reg        <= 1'b0;
    end else begin
      ud_run_prev_reg <= ud_run;
      qd_run_prev_reg <= qd_run;
      ud_cnt_reg      <= ud_cnt_next;
      qd_cnt_reg      <= qd_cnt_next;
      ud_q_reg <= ~ud_rst &
                  ($signed(ud_cnt_next) >= $signed(udpre_reg));
      qd_q_reg <= ~qd_rst &
                  ($signed(qd_cnt_next) >= $signed(qdpre_reg));
    end
  end

  // APB decode: no wait state, answer registered in the setup cycle
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_mux;
  logic        rd_hit;
  wire setup = psel_in & ~penable_in;
  wire wr_go = psel_in & penable_in & pwrite_in & pready_reg & ~pslverr_reg;
  wire wr_ro = pwrite_in & (paddr_in >= `OFS_RATE);
  always_comb begin
    rd_hit = 1'b1;
    unique case (paddr_in)
      `OFS_CTRL:  rd_mux = {23'h0, ctrl_reg};
      `OFS_ON:    rd_mux = on_reg;
      `OFS_OFF:   rd_mux = off_reg;
      `OFS_GATE:  rd_mux = gate_reg;
      `OFS_UDPRE: rd_mux = udpre_reg;
      `OFS_QDPRE: rd_mux = qdpre_reg;
      `OFS_RATE:  rd_mux = rate_reg;
      `OFS_UDVAL: rd_mux = ud_cnt_reg;
      `OFS_QDVAL: rd_mux = qd_cnt_reg;
      `OFS_STAT:  rd_mux = {28'h0, qd_q_reg, ud_q_reg, rate_q_reg,
                            measuring};
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Bus answer flops; a read-only or unmapped write gets an error
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & (~rd_hit | wr_ro);
      if (setup) prdata_reg <= pwrite_in ? 32'h0 : rd_mux;
    end
  end

  // Register writes, limited to the legal ranges
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_reg  <= `CTRL_RST;
      on_reg    <= `ON_RST;
      off_reg   <= `OFF_RST;
      gate_reg  <= `GATE_RST;
      udpre_reg <= `PRE_RST;
      qdpre_reg <= `PRE_RST;
    end else if (wr_go) begin
      unique case (paddr_in)
        `OFS_CTRL:  ctrl_reg <= pwdata_in[8:0];
        `OFS_ON:    on_reg <= clamp(pwdata_in, 32'h0, `ON_MAX);
        `OFS_OFF:   off_reg <= clamp(pwdata_in, 32'h0, `OFF_MAX);
        `OFS_GATE:  gate_reg <= clamp(pwdata_in, `GATE_MIN,
                                      `GATE_MAX);
        `OFS_UDPRE: udpre_reg <= clamp(pwdata_in, 32'h0, `PRE_MAX);
        `OFS_QDPRE: qdpre_reg <= clamp(pwdata_in, 32'h0, `PRE_MAX);
        default:    ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Outputs straight from flops; value taps follow running values
  assign pready_out     = pready_reg;
  assign pslverr_out    = pslverr_reg;
  assign prdata_out     = prdata_reg;
  assign rate_q_out     = rate_q_reg;
  assign ud_q_out       = ud_q_reg;
  assign qd_q_out       = qd_q_reg;
  assign rate_value_out = rate_reg;
  assign ud_value_out   = ud_cnt_reg;
  assign qd_value_out   = qd_cnt_reg;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence rate_start_seq;
    (state_reg == RATE_IDLE) && en_rise;
  endsequence
  sequence up_only_seq;
    !ud_clr && ud_inc && !ud_dec;
  endsequence
  sequence qd_x4_lead_seq;
    !qd_clr && qd_run && qd_mode == QD_X4 && ea && !eb && a && !b;
  endsequence

  AST_RATE_START: assert property (rate_start_seq |=> measuring)
    else $error("rate switch did not start");
  AST_RATE_STOP: assert property (measuring && en_fall |=> !measuring)
    else $error("rate switch did not stop");
  AST_RATE_RST: assert property (rate_rst |=>
      !rate_q_out && edge_reg == 32'h0)
    else $error("rate reset did not clear");
  AST_HOLD: assert property (gate_end && on_reg >= off_reg &&
      rate_new < on_reg && rate_new >= off_reg |=> $stable(rate_q_out))
    else $error("hysteresis did not hold");
  AST_WINDOW: assert property (gate_end && on_reg < off_reg |=>
      rate_q_out == (rate_reg >= on_reg && rate_reg < off_reg))
    else $error("window output wrong");
  AST_UD_UP: assert property (up_only_seq |=>
      ud_value_out == $past(ud_value_out) + 32'h1)
    else $error("up count missed");
  AST_UD_RST: assert property (ud_rst |=> ud_value_out == 32'h0 &&
      !ud_q_out)
    else $error("up/down reset did not clear");
  AST_QD_RST: assert property (qd_rst |=> qd_value_out == 32'h0 &&
      !qd_q_out)
    else $error("quadrature reset did not clear");
  AST_QD_DIR: assert property (qd_x4_lead_seq |=>
      qd_value_out == $past(qd_value_out) + 32'h1)
    else $error("quadrature direction wrong");
  AST_QD_Q: assert property (!qd_rst |=>
      qd_q_out == ($signed(qd_cnt_reg) >= $signed($past(qdpre_reg))))
    else $error("quadrature output wrong");
endmodule

// ---- rtl/fpc_cfg.svh ----
/*
  Offsets, field positions, reset values, limits and timing counts of the
  fast pulse counter block. Assumes a 100 MHz system clock.
*/
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH
// Register byte offsets
`define OFS_CTRL    8'h00
`define OFS_ON      8'h04
`define OFS_OFF     8'h08
`define OFS_GATE    8'h0c
`define OFS_UDPRE   8'h10
`define OFS_QDPRE   8'h14
`define OFS_RATE    8'h18
`define OFS_UDVAL   8'h1c
`define OFS_QDVAL   8'h20
`define OFS_STAT    8'h24
// Control field positions
`define CTL_FALL    0
`define CTL_RHS     1
`define CTL_UHS     2
`define CTL_URET    3
`define CTL_QRET    4
`define CTL_QM_LO   5
`define CTL_QM_HI   6
`define CTL_URUN    7
`define CTL_QRUN    8
// Reset values
`define CTRL_RST    9'h000
`define ON_RST      32'h0000_0000
`define OFF_RST     32'h0000_0000
`define GATE_RST    32'h0000_0001
`define PRE_RST     32'h0000_0000
// Value limits: 99999999, 999999999, gate in 10 ms ticks up to 999:59:59.990
`define ON_MAX      32'h05f5_e0ff
`define OFF_MAX     32'h3b9a_c9ff
`define PRE_MAX     32'h05f5_e0ff
`define GATE_MIN    32'h0000_0001
`define GATE_MAX    32'h1575_29ff
// Timing: clock in kHz, times in ms, counts derived
`define CLK_KHZ     100000
`define FILT_MS     50
`define TICK_MS     10
`define FILT_CYC    (`FILT_MS * `CLK_KHZ)
`define TICK_CYC    (`TICK_MS * `CLK_KHZ)
`endif

// ---- rtl/fpc_pkg.sv ----
/*
  Types of the fast pulse counter block.
  Assumes the constants of fpc_cfg.svh.
*/
package fpc_pkg;
  // Measuring state of the rate threshold switch
  typedef enum logic [1:0] {
    RATE_IDLE = 2'b01,
    RATE_MEAS = 2'b10
  } rate_state_type;
  // Quadrature decoding factor
  typedef enum logic [1:0] {
    QD_X1 = 2'h0,
    QD_X2 = 2'h1,
    QD_X4 = 2'h2
  } qd_mode_type;
endpackage
